// file: hw/asr_regs.sv
// Angle, status, fault and warning registers with the device control register.
//
// Decided for this implementation: strobed register access.
`default_nettype none
module asr_regs
    import asr_pkg::*;
(
    input  wire logic              sys_clk,            // System clock, 250 MHz.
    input  wire logic              arst_n,             // Asynchronous reset, active low.
    input  wire logic [ADDR_W-1:0] reg_addr,           // Register address.
    input  wire logic [DATA_W-1:0] reg_wdata,          // Register write data.
    input  wire logic              reg_wr,             // Write strobe.
    input  wire logic              reg_rd,             // Read strobe.
    output logic      [DATA_W-1:0] reg_rdata,          // Read data, one cycle later.
    input  wire logic [11:0]       angle_code,         // Tracked angle.
    input  wire logic              loop_locked,        // Tracking loop locked.
    input  wire logic              nv_loaded,          // Nonvolatile load finished.
    input  wire logic              tests_done,         // Startup self-tests finished.
    input  wire logic              boot_active,        // Boot sequence under way.
    input  wire logic [1:0]        chip_index_nv,      // Chip index from memory.
    input  wire logic              dir_decreasing,     // Hysteresis sees falling angle.
    input  wire logic              speed_over_sleep,   // Speed above sleep threshold.
    input  wire logic              sleep_request,      // Sleep entry wanted.
    input  wire logic              logic_test_running, // Logic self-test running.
    input  wire logic              hall_test_running,  // Front-end self-test running.
    input  wire logic              logic_test_fail,    // Logic self-test failed.
    input  wire logic              hall_test_fail,     // Front-end self-test failed.
    input  wire logic              action_complete,    // Triggered action finished.
    input  wire logic              mean_err_evt,       // Averaged angle corrupted.
    input  wire logic              quad_err_evt,       // Quadrature output broken.
    input  wire logic              lock_lost_evt,      // Tracking loop lost lock.
    input  wire logic              zc_timeout_evt,     // Zero crossing overdue.
    input  wire logic              nv_double_evt,      // Uncorrectable memory error.
    input  wire logic              osc_trip_evt,       // Oscillator watchdog tripped.
    input  wire logic              vcc_low,            // Supply pin undervoltage, level.
    input  wire logic              reg_low,            // Regulator undervoltage, level.
    input  wire logic              mag_low_evt,        // Field below low limit.
    input  wire logic [11:0]       warn_evt,           // Warning conditions.
    input  wire logic [11:0]       fault_mask,         // Nonvolatile fault masks.
    input  wire logic [11:0]       warn_mask,          // Nonvolatile warning masks.
    output logic                   start_hall_test,    // Pulse: start front-end test.
    output logic                   start_logic_test,   // Pulse: start logic test.
    output logic                   turns_reset,        // Pulse: reset turns count.
    output logic                   hard_reset,         // Pulse: hard reset.
    output logic                   sleep_enter_ok      // Sleep entry permitted.
);
    logic [10:0]       fault_q;
    logic [11:0]       warn_q;
    logic [10:0]       f_set;
    logic [11:0]       w_set;
    logic              ctrl_wr;
    logic              clr_faults;
    logic              clr_cautions;
    logic              clr_done;
    logic              rd_fault;
    logic              rd_warn;
    logic              caution_sum;
    logic              fault_sum;
    logic              supply_low;
    logic [DATA_W-1:0] angle_word;
    logic [DATA_W-1:0] status_word;
    logic [DATA_W-1:0] fault_word;
    logic [DATA_W-1:0] ctrl_word;
    logic [3:0]        action_select;
    logic              special_done;
    logic              act_busy;
    logic              boot_done;
    logic              boot_fin;
    logic              boot_fin_q;
    logic              output_valid;
    logic [1:0]        chip_index;
    logic              turn_direction;
    logic              sleep_blocked_velocity;

    // Register decode.
    assign ctrl_wr      = reg_wr && reg_addr == OFF_CTRL;
    assign clr_faults   = ctrl_wr && reg_wdata[CTL_CLR_FLT];
    assign clr_cautions = ctrl_wr && reg_wdata[CTL_CLR_CAUT];
    assign clr_done     = ctrl_wr && reg_wdata[CTL_CLR_DONE];
    assign rd_fault     = reg_rd && reg_addr == OFF_FAULT;
    assign rd_warn      = reg_rd && reg_addr == OFF_WARN;

    // Supply faults are levels, so they keep setting the bit while present.
    assign f_set = {logic_test_fail | hall_test_fail,
                    mean_err_evt, quad_err_evt,
                    lock_lost_evt, zc_timeout_evt,
                    nv_double_evt, osc_trip_evt, vcc_low, reg_low,
                    mag_low_evt, hard_reset};
    assign w_set = warn_evt & ~WARN_RSVD;

    asr_sticky #(
        .W       (11),
        .RST_VAL (FAULT_RST_VAL)
    ) u_fault (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .set_evt (f_set),
        .rd_hit  (rd_fault),
        .clr     (clr_faults),
        .flags   (fault_q)
    );

    asr_sticky #(
        .W       (12),
        .RST_VAL (WARN_RST_VAL)
    ) u_warn (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .set_evt (w_set),
        .rd_hit  (rd_warn),
        .clr     (clr_cautions),
        .flags   (warn_q)
    );

    asr_action u_action (
        .sys_clk         (sys_clk),
        .arst_n          (arst_n),
        .ctrl_wr         (ctrl_wr),
        .sel_wr          (reg_wdata[CTL_SEL_LSB +: 4]),
        .trig_wr         (reg_wdata[7:0]),
        .clr_done        (clr_done),
        .action_complete (action_complete),
        .action_select   (action_select),
        .special_done    (special_done),
        .busy            (act_busy),
        .start_hall      (start_hall_test),
        .start_logic     (start_logic_test),
        .turns_reset     (turns_reset),
        .hard_reset      (hard_reset)
    );

    // Summaries.
    assign caution_sum = (|(warn_q & ~warn_mask)) && !fault_mask[FB_CAUTION];
    assign fault_sum   = (|(fault_q & ~fault_mask[10:0])) || (|(warn_q & ~warn_mask));
    assign supply_low  = (vcc_low && !fault_mask[FB_VCC])
                      || (reg_low && !fault_mask[FB_REG]);

    // Angle word: the check bit is chosen so the word always has an odd count of ones.
    always_comb begin
        angle_word            = '0;
        angle_word[11:0]      = angle_code;
        angle_word[AW_SUM]    = fault_sum;
        angle_word[AW_SUPPLY] = supply_low;
        angle_word[AW_ODD]    = ~^{fault_sum, supply_low, angle_code};
    end

    always_comb begin
        status_word        = '0;
        status_word[15:12] = TAG_STATUS;
        status_word[9:8]   = chip_index;
        status_word[7]     = turn_direction;
        status_word[6]     = sleep_blocked_velocity;
        status_word[5]     = special_done;
        status_word[4]     = boot_done;
        status_word[3]     = logic_test_running;
        status_word[2]     = hall_test_running;
        status_word[1]     = boot_active;
        status_word[0]     = output_valid;
    end

    assign fault_word = {TAG_FAULT, caution_sum, fault_q};

    // Clear and trigger bits are write-only; only the selection reads back.
    assign ctrl_word = {action_select, 12'h000};

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                OFF_CTRL:   reg_rdata <= ctrl_word;
                OFF_ANGLE:  reg_rdata <= angle_word;
                OFF_STATUS: reg_rdata <= status_word;
                OFF_FAULT:  reg_rdata <= fault_word;
                OFF_WARN:   reg_rdata <= {TAG_WARN, warn_q};
                default:    reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

    // Boot done sets on the cycle load and startup tests both become finished.
    assign boot_fin = nv_loaded && tests_done;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            boot_fin_q <= 1'b0;
        end else begin
            boot_fin_q <= boot_fin;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            boot_done <= 1'b0;
        end else if (boot_fin && !boot_fin_q) begin
            boot_done <= 1'b1;
        end else if (clr_done) begin
            boot_done <= 1'b0;
        end
    end

    // Valid needs lock and a finished startup; the clearable done flag is not used.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            output_valid <= 1'b0;
        end else begin
            output_valid <= loop_locked && boot_fin && !boot_active;
        end
    end

    // Chip index is reported only and steers nothing else.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            chip_index <= 2'h0;
        end else if (nv_loaded) begin
            chip_index <= chip_index_nv;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            turn_direction         <= 1'b0;
            sleep_blocked_velocity <= 1'b0;
            sleep_enter_ok         <= 1'b0;
        end else begin
            turn_direction         <= dir_decreasing;
            sleep_blocked_velocity <= speed_over_sleep;
            sleep_enter_ok         <= sleep_request && !speed_over_sleep;
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);

    sequence s_fault_seen;
        rd_fault && f_set == 11'h000;
    endsequence

    sequence s_fault_clear;
        clr_faults && f_set == 11'h000;
    endsequence

    sequence s_warn_seen;
        rd_warn && w_set == 12'h000;
    endsequence

    sequence s_warn_clear;
        clr_cautions && w_set == 12'h000;
    endsequence

    // A clear write one cycle after a read drops what it returned; this checks a three-cycle gap.
    property p_caut_clear;
        s_warn_seen ##1 (w_set == 12'h000)[*2] ##1 s_warn_clear |=> warn_q == 12'h000;
    endproperty
    a_caut_clear: assert property (p_caut_clear) else $error("read warnings not cleared");

    property p_fault_clear;
        s_fault_seen ##1 (f_set == 11'h000)[*2] ##1 s_fault_clear |=> fault_q == 11'h000;
    endproperty
    a_fault_clear: assert property (p_fault_clear) else $error("read faults not cleared");

    property p_ctrl_reads;
        reg_rd && reg_addr == OFF_CTRL |=> reg_rdata[11:0] == 12'h000;
    endproperty
    a_ctrl_reads: assert property (p_ctrl_reads) else $error("write-only bits read back");

    property p_trig_hall;
        ctrl_wr && !act_busy && reg_wdata == 16'h90b9
            |=> start_hall_test && !start_logic_test && !special_done;
    endproperty
    a_trig_hall: assert property (p_trig_hall) else $error("self-test trigger missed");

    property p_odd_word;
        reg_rd && reg_addr == OFF_ANGLE |=> ^reg_rdata && !reg_rdata[15];
    endproperty
    a_odd_word: assert property (p_odd_word) else $error("angle word parity not odd");

    property p_sum_flag;
        reg_rd && reg_addr == OFF_ANGLE && |(fault_q & ~fault_mask[10:0])
            |=> reg_rdata[AW_SUM];
    endproperty
    a_sum_flag: assert property (p_sum_flag) else $error("summary flag missing");

    property p_tags;
        reg_rd && reg_addr == OFF_FAULT |=> reg_rdata[15:12] == 4'ha;
    endproperty
    a_tags: assert property (p_tags) else $error("fault tag wrong");

    property p_done_cause;
        $rose(special_done) |-> $past(action_complete);
    endproperty
    a_done_cause: assert property (p_done_cause) else $error("done set without completion");

    property p_boot_done;
        boot_fin && !boot_fin_q |=> boot_done;
    endproperty
    a_boot_done: assert property (p_boot_done) else $error("boot done not set");

    property p_valid;
        output_valid |-> $past(loop_locked) && $past(boot_fin);
    endproperty
    a_valid: assert property (p_valid) else $error("valid without lock");

    property p_set_wins;
        clr_faults |=> (fault_q & $past(f_set)) == $past(f_set);
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("new fault lost on clear");
endmodule : asr_regs
`default_nettype wire

// file: hw/asr_pkg.sv
// Constants and types shared by the angle sensor status and fault register set.
`default_nettype none
package asr_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;

    // Register offsets.
    localparam logic [7:0] OFF_CTRL   = 8'h1e;
    localparam logic [7:0] OFF_ANGLE  = 8'h20;
    localparam logic [7:0] OFF_STATUS = 8'h22;
    localparam logic [7:0] OFF_FAULT  = 8'h24;
    localparam logic [7:0] OFF_WARN   = 8'h26;

    // Device control fields.
    localparam int CTL_SEL_LSB   = 12;
    localparam int CTL_CLR_DONE  = 10;
    localparam int CTL_CLR_CAUT  = 9;
    localparam int CTL_CLR_FLT   = 8;

    // Action selections and trigger codes.
    localparam logic [3:0] SEL_TURNS = 4'h4;
    localparam logic [3:0] SEL_HARD  = 4'h7;
    localparam logic [3:0] SEL_HALL  = 4'h9;
    localparam logic [3:0] SEL_LOGIC = 4'ha;
    localparam logic [3:0] SEL_BOTH  = 4'hb;
    localparam logic [7:0] TRIG_TEST  = 8'hb9;
    localparam logic [7:0] TRIG_TURNS = 8'h46;
    localparam logic [7:0] TRIG_HARD  = 8'h5a;

    // Fixed register tags in bits 15:12.
    localparam logic [3:0] TAG_STATUS = 4'h8;
    localparam logic [3:0] TAG_FAULT  = 4'ha;
    localparam logic [3:0] TAG_WARN   = 4'hb;

    // Angle word bit positions.
    localparam int AW_SUM    = 14;
    localparam int AW_SUPPLY = 13;
    localparam int AW_ODD    = 12;

    // Fault bit positions.
    localparam int FB_CAUTION = 11;
    localparam int FB_VCC     = 3;
    localparam int FB_REG     = 2;

    // Values after reset: the reset flag of the fault register starts set.
    localparam logic [10:0] FAULT_RST_VAL = 11'h001;
    localparam logic [11:0] WARN_RST_VAL  = 12'h000;
    localparam logic [11:0] WARN_RSVD     = 12'h200;
    localparam logic [3:0]  SEL_RST_VAL   = 4'h0;

    typedef enum logic [0:0] {ACT_IDLE, ACT_BUSY} asr_act_t;
endpackage : asr_pkg
`default_nettype wire

// file: hw/asr_sticky.sv
// Latched flag set that remembers which set bits a read has returned.
`default_nettype none
module asr_sticky
    import asr_pkg::*;
#(
    parameter int          W       = 11,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         sys_clk, // System clock.
    input  wire logic         arst_n,  // Asynchronous reset, active low.
    input  wire logic [W-1:0] set_evt, // Conditions that latch a bit.
    input  wire logic         rd_hit,  // Register read this cycle.
    input  wire logic         clr,     // Clear of the bits already read.
    output logic      [W-1:0] flags    // Latched flags.
);
    logic [W-1:0] seen;

    // A clear drops only bits a read returned; an event in the same cycle still wins.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            flags <= RST_VAL;
        end else if (clr) begin
            flags <= (flags & ~seen) | set_evt;
        end else begin
            flags <= flags | set_evt;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            seen <= '0;
        end else if (clr) begin
            seen <= '0;
        end else if (rd_hit) begin
            seen <= seen | flags;
        end
    end
endmodule : asr_sticky
`default_nettype wire

// file: hw/asr_action.sv
// Action selection, trigger decode and completion flag of the control register.
`default_nettype none
module asr_action
    import asr_pkg::*;
(
    input  wire logic       sys_clk,         // System clock.
    input  wire logic       arst_n,          // Asynchronous reset, active low.
    input  wire logic       ctrl_wr,         // Write to the control register.
    input  wire logic [3:0] sel_wr,          // Written action selection.
    input  wire logic [7:0] trig_wr,         // Written trigger code.
    input  wire logic       clr_done,        // Clear of the done flags.
    input  wire logic       action_complete, // Action engine finished.
    output logic      [3:0] action_select,   // Current selection.
    output logic            special_done,    // Action done flag.
    output logic            busy,            // An action is under way.
    output logic            start_hall,      // Start front-end self-test.
    output logic            start_logic,     // Start logic self-test.
    output logic            turns_reset,     // Reset turns count.
    output logic            hard_reset       // Hard reset request.
);
    asr_act_t state;
    logic     fire;

    function automatic logic trig_ok(input logic [3:0] s, input logic [7:0] t);
        trig_ok = ((s == SEL_HALL || s == SEL_LOGIC || s == SEL_BOTH) && t == TRIG_TEST)
               || (s == SEL_TURNS && t == TRIG_TURNS)
               || (s == SEL_HARD && t == TRIG_HARD);
    endfunction : trig_ok

    // Triggers while an action runs are ignored.
    assign fire = ctrl_wr && state == ACT_IDLE && trig_ok(sel_wr, trig_wr);
    assign busy = (state == ACT_BUSY);

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= ACT_IDLE;
        end else begin
            case (state)
                ACT_IDLE: if (fire) state <= ACT_BUSY;
                ACT_BUSY: if (action_complete) state <= ACT_IDLE;
                default:  state <= ACT_IDLE;
            endcase
        end
    end

    // The selection reads back and returns to zero once the action completes.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            action_select <= SEL_RST_VAL;
        end else if (busy && action_complete) begin
            action_select <= SEL_RST_VAL;
        end else if (ctrl_wr) begin
            action_select <= sel_wr;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            special_done <= 1'b0;
        end else if (busy && action_complete) begin
            special_done <= 1'b1;
        end else if (fire || clr_done) begin
            special_done <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            start_hall  <= 1'b0;
            start_logic <= 1'b0;
            turns_reset <= 1'b0;
            hard_reset  <= 1'b0;
        end else begin
            start_hall  <= fire && (sel_wr == SEL_HALL || sel_wr == SEL_BOTH);
            start_logic <= fire && (sel_wr == SEL_LOGIC || sel_wr == SEL_BOTH);
            turns_reset <= fire && sel_wr == SEL_TURNS;
            hard_reset  <= fire && sel_wr == SEL_HARD;
        end
    end
endmodule : asr_action
`default_nettype wire

// file: tb/asr_host.sv
// Host controller model that issues register reads and writes.
`default_nettype none
module asr_host
    import asr_pkg::*;
(
    input  wire logic              sys_clk,   // System clock.
    input  wire logic [DATA_W-1:0] reg_rdata, // Read data.
    output var logic  [ADDR_W-1:0] reg_addr,  // Address.
    output var logic  [DATA_W-1:0] reg_wdata, // Write data.
    output var logic               reg_wr,    // Write strobe.
    output var logic               reg_rd     // Read strobe.
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    // The select and its trigger code travel in one word.
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(posedge sys_clk);
        d = reg_rdata;
    endtask : rd
endmodule : asr_host
`default_nettype wire

// file: tb/angle_sensor_status_error_regs_tb.sv
// Self-checking bench for the status and fault register set.
`default_nettype none
module angle_sensor_status_error_regs_tb
    import asr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk, arst_n, reg_wr, reg_rd, loop_locked, nv_loaded, tests_done;
    logic boot_active, dir_decreasing, speed_over_sleep, sleep_request, logic_test_running;
    logic hall_test_running, logic_test_fail, hall_test_fail, action_complete;
    logic vcc_low, reg_low, sh, sl, tr, hr, sleep_ok;
    logic [7:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, got;
    logic [11:0] angle_code, warn_evt, fault_mask, warn_mask;
    logic [1:0]  chip_index_nv;
    logic [6:0]  ev;
    int bad_count, comparisons, n_h, n_l, n_t, n_r;
    logic [15:0] cw [6] = '{16'h90b9, 16'ha0b9, 16'hb0b9, 16'h4046, 16'h705a, 16'h40b9};
    asr_host host (.sys_clk, .reg_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);
    asr_regs dut (.sys_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .angle_code, .loop_locked, .nv_loaded, .tests_done, .boot_active, .chip_index_nv,
        .dir_decreasing, .speed_over_sleep, .sleep_request, .logic_test_running,
        .hall_test_running, .logic_test_fail, .hall_test_fail, .action_complete,
        .mean_err_evt(ev[0]), .quad_err_evt(ev[1]), .lock_lost_evt(ev[2]),
        .zc_timeout_evt(ev[3]), .nv_double_evt(ev[4]), .osc_trip_evt(ev[5]),
        .vcc_low, .reg_low, .mag_low_evt(ev[6]), .warn_evt, .fault_mask, .warn_mask,
        .start_hall_test(sh), .start_logic_test(sl), .turns_reset(tr), .hard_reset(hr),
        .sleep_enter_ok(sleep_ok));
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // Pulses last one cycle, so they are counted at every edge.
    always @(posedge sys_clk) begin
        n_h += int'(sh);
        n_l += int'(sl);
        n_t += int'(tr);
        n_r += int'(hr);
    end
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        comparisons++;
        if (g !== e) begin
            bad_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic rc(input logic [7:0] a, input logic [15:0] e);
        host.rd(a, got);
        chk(got, e);
    endtask : rc
    task automatic finish_test;
        $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test
    initial begin
        #20us;
        bad_count++;
        finish_test();
    end
    initial begin
        {arst_n, reg_low, vcc_low, ev, loop_locked, nv_loaded, tests_done} = '0;
        {boot_active, dir_decreasing, speed_over_sleep, sleep_request} = '0;
        {logic_test_running, hall_test_running, logic_test_fail, hall_test_fail} = '0;
        {action_complete, warn_evt, fault_mask, warn_mask, chip_index_nv} = '0;
        angle_code = 12'h123;
        repeat (3) @(posedge sys_clk);
        arst_n <= 1'b1;
        rc(OFF_FAULT, 16'ha001);
        rc(8'h30, 16'h0000);
        rc(OFF_ANGLE, 16'h4123);
        {loop_locked, nv_loaded, tests_done, dir_decreasing, speed_over_sleep} <= '1;
        {boot_active, logic_test_running, hall_test_running, sleep_request} <= '1;
        chip_index_nv <= 2'b10;
        repeat (3) @(posedge sys_clk);
        rc(OFF_STATUS, 16'h82de);
        chk(16'(sleep_ok), 16'h0000);
        {boot_active, logic_test_running, hall_test_running, speed_over_sleep} <= '0;
        ev <= 7'h7f;
        hall_test_fail <= 1'b1;
        @(posedge sys_clk);
        {ev, hall_test_fail} <= '0;
        host.wr(OFF_CTRL, 16'h0500);
        rc(OFF_STATUS, 16'h8281);
        chk(16'(sleep_ok), 16'h0001);
        rc(OFF_FAULT, 16'ha7f2);
        host.wr(OFF_CTRL, 16'h0100);
        rc(OFF_FAULT, 16'ha000);
        rc(OFF_ANGLE, 16'h1123);
        for (int i = 0; i < 6; i++) begin
            host.wr(OFF_CTRL, cw[i]);
            if (i < 5) begin
                rc(OFF_CTRL, cw[i] & 16'hf000);
                rc(OFF_STATUS, 16'h8281);
                @(posedge sys_clk);
                action_complete <= 1'b1;
                @(posedge sys_clk);
                action_complete <= 1'b0;
                rc(OFF_STATUS, 16'h82a1);
            end
        end
        chk(16'(n_h), 16'h0002);
        chk(16'(n_l), 16'h0002);
        chk(16'(n_t), 16'h0001);
        chk(16'(n_r), 16'h0001);
        rc(OFF_STATUS, 16'h82a1);
        host.wr(OFF_CTRL, 16'h0400);
        rc(OFF_STATUS, 16'h8281);
        {vcc_low, reg_low} <= 2'b11;
        repeat (2) @(posedge sys_clk);
        rc(OFF_ANGLE, 16'h7123);
        fault_mask <= 12'h00c;
        rc(OFF_ANGLE, 16'h4123);
        {vcc_low, reg_low} <= 2'b00;
        fault_mask <= 12'h000;
        rc(OFF_FAULT, 16'ha00d);
        warn_evt <= 12'h201;
        @(posedge sys_clk);
        warn_evt <= 12'h000;
        rc(OFF_FAULT, 16'ha80d);
        fault_mask <= 12'h800;
        rc(OFF_FAULT, 16'ha00d);
        host.wr(OFF_CTRL, 16'h0100);
        rc(OFF_ANGLE, 16'h4123);
        warn_mask <= 12'h001;
        rc(OFF_ANGLE, 16'h1123);
        rc(OFF_WARN, 16'hb001);
        host.wr(OFF_CTRL, 16'h0200);
        rc(OFF_WARN, 16'hb000);
        finish_test();
    end
endmodule : angle_sensor_status_error_regs_tb
`default_nettype wire
